// ---- verilog/rsp_pkg.sv ----
// Purpose: Shared constants for the remote status port command handler.
// Assumes: Characters are 8-bit ASCII codes.
// Notes:   Frame control codes, port field positions and command limits.
package rsp_pkg;
  localparam logic [7:0] CH_STX   = 8'h02;
  localparam logic [7:0] CH_ETX   = 8'h03;
  localparam logic [7:0] CH_EOT   = 8'h04;
  localparam logic [7:0] CH_ENQ   = 8'h05;
  localparam logic [7:0] CH_ACK   = 8'h06;
  localparam logic [7:0] CH_NAK   = 8'h15;
  localparam logic [7:0] CH_SPACE = 8'h20;
  localparam logic [7:0] CH_ZERO  = 8'h30;
  localparam logic [7:0] CH_ONE   = 8'h31;
  localparam logic [7:0] CH_NINE  = 8'h39;
  localparam logic [7:0] CH_UPA   = 8'h41;
  localparam logic [7:0] CH_UPF   = 8'h46;
  localparam logic [7:0] CH_GT    = 8'h3e;
  localparam logic [7:0] HEX_LOW  = 8'h30;
  localparam logic [7:0] HEX_HIGH = 8'h37;

  localparam int ADDR_ZEROS  = 4;
  localparam int PAYLOAD_MAX = 5;
  localparam int REPLY_MAX   = 10;

  localparam logic [6:0] LEVEL_MAX   = 7'h64;
  localparam logic [6:0] LEVEL_RESET = 7'h00;
  localparam logic [7:0] DAC_RESET   = 8'h00;

  localparam int MP_HEATER  = 0;
  localparam int MP_SPARE_A = 1;
  localparam int MP_EVAP    = 2;
  localparam int MP_SPARE_B = 3;
  localparam int MP_VALVE   = 4;
  localparam int JMP_EVAP   = 3;

  typedef enum logic [3:0] {
    RSP_CMD_NONE,
    RSP_CMD_HEATER,
    RSP_CMD_STATUS,
    RSP_CMD_LEVEL,
    RSP_CMD_EVAP_SW,
    RSP_CMD_MAIN,
    RSP_CMD_DAC,
    RSP_CMD_INTERNAL,
    RSP_CMD_JUMPER
  } rsp_cmd_e;
endpackage

// ---- verilog/rsp_cmd_port.sv ----
// Purpose: Framed ASCII command interpreter for heater, evaporator, ports.
// Assumes: Characters arrive deserialised; replies leave one per handshake.
// Notes:   One request is served at a time; input stalls while replying.
`timescale 1ns/1ps
module rsp_cmd_port
  import rsp_pkg::*;
(
  input  wire logic       MCLK,
  input  wire logic       RST_N,
  input  wire logic [7:0] RX_DATA,
  input  wire logic       RX_VALID,
  output logic            RX_READY,
  output logic [7:0]      TX_DATA,
  output logic            TX_VALID,
  input  wire logic       TX_READY,
  input  wire logic       EVAP_ATTACHED,
  input  wire logic       GAS_MISSING,
  input  wire logic       OVERHEAT,
  input  wire logic       EXCH_ATTACHED,
  input  wire logic       LN2_REFILL,
  input  wire logic       LN2_EMPTY,
  input  wire logic       BOOSTER_ATTACHED,
  input  wire logic [3:0] VALVE_JUMPER,
  output logic            HEATER_ON,
  output logic            EVAP_HEATER_ON,
  output logic            SPARE_OUTPUT_A,
  output logic            SPARE_OUTPUT_B,
  output logic [3:0]      VALVE_OUT,
  output logic [7:0]      EVAP_DAC_CODE,
  output logic [6:0]      EVAP_POWER_LEVEL
);

  typedef enum logic [3:0] {
    ST_IDLE, ST_ADDR, ST_FIRST, ST_RCMD1, ST_RENQ,
    ST_WCMD0, ST_WCMD1, ST_WDATA, ST_WBCC, ST_EXEC, ST_SEND
  } rsp_state_e;

  rsp_state_e  state;
  rsp_cmd_e    cmd;
  logic [7:0]  cmd_c0;
  logic [7:0]  cmd_c1_q;
  logic [2:0]  addr_cnt;
  logic        is_write;
  logic        bad;
  logic [7:0]  pay [PAYLOAD_MAX];
  logic [2:0]  pay_len;
  logic [7:0]  rx_bcc;
  logic [7:0]  rep [REPLY_MAX];
  logic [3:0]  rep_len;
  logic [3:0]  tx_idx;
  logic        init_done;
  logic [7:0]  main_port;

  logic        take;
  logic [7:0]  next_rep [REPLY_MAX];
  logic [3:0]  next_rep_len;
  logic        wr_main;
  logic        wr_dac;
  logic        wr_level;
  logic        wr_heater;
  logic        wr_evap;
  logic [7:0]  hex_byte;
  logic        hex_ok;
  logic        bit_ok;
  logic [9:0]  dec_val;
  logic        dec_ok;
  logic [15:0] status_word;
  logic [7:0]  internal_port;
  logic [7:0]  jumper_port;
  logic [7:0]  read_byte;

  function automatic logic [7:0] hex_char(input logic [3:0] n);
    hex_char = (n < 4'ha) ? HEX_LOW + {4'h0, n} : HEX_HIGH + {4'h0, n};
  endfunction

  function automatic logic [4:0] hex_val(input logic [7:0] c);
    if (c >= CH_ZERO && c <= CH_NINE)
      hex_val = {1'b1, c[3:0]};
    else if (c >= CH_UPA && c <= CH_UPF)
      hex_val = {1'b1, c[3:0] + 4'h9};
    else
      hex_val = 5'h00;
  endfunction

  function automatic rsp_cmd_e decode(input logic [7:0] a,
                                      input logic [7:0] b);
    unique case ({a, b})
      "HP":    decode = RSP_CMD_HEATER;
      "IS":    decode = RSP_CMD_STATUS;
      "NH":    decode = RSP_CMD_LEVEL;
      "NP":    decode = RSP_CMD_EVAP_SW;
      "P1":    decode = RSP_CMD_MAIN;
      "P2":    decode = RSP_CMD_DAC;
      "P3":    decode = RSP_CMD_INTERNAL;
      "P4":    decode = RSP_CMD_JUMPER;
      default: decode = RSP_CMD_NONE;
    endcase
  endfunction

  assign take = RX_VALID && RX_READY;

  // Live input sampling; nothing is latched between requests
  assign status_word = {5'h00, BOOSTER_ATTACHED, 1'b1,
                        main_port[MP_EVAP],
                        LN2_EMPTY, LN2_REFILL, EXCH_ATTACHED, OVERHEAT,
                        GAS_MISSING, EVAP_ATTACHED, 1'b0,
                        main_port[MP_HEATER]};
  assign internal_port = {LN2_EMPTY, LN2_REFILL, EXCH_ATTACHED,
                          OVERHEAT, GAS_MISSING, EVAP_ATTACHED,
                          BOOSTER_ATTACHED, main_port[MP_HEATER]};
  assign jumper_port = {VALVE_JUMPER, main_port[MP_EVAP], 3'h0};

  // Payload checks
  always_comb begin
    logic [4:0] hi;
    logic [4:0] lo;
    logic       lead;
    hi = hex_val(pay[0]);
    lo = hex_val(pay[1]);
    hex_ok = (pay_len == 3'd2) && hi[4] && lo[4];
    hex_byte = {hi[3:0], lo[3:0]};
    bit_ok = (pay_len == 3'd1) &&
             (pay[0] == CH_ZERO || pay[0] == CH_ONE);
    dec_val = 10'h000;
    dec_ok = (pay_len != 3'd0);
    lead = 1'b1;
    for (int i = 0; i < PAYLOAD_MAX; i++) begin
      if (i < int'(pay_len)) begin
        if (lead && pay[i] == CH_SPACE) begin
          dec_val = dec_val;
        end else if (pay[i] >= CH_ZERO && pay[i] <= CH_NINE &&
                     dec_val <= 10'h00a) begin
          lead = 1'b0;
          dec_val = 10'((dec_val * 10'd10) + {6'h00, pay[i][3:0]});
        end else begin
          dec_ok = 1'b0;
        end
      end
    end
    if (dec_val > {3'h0, LEVEL_MAX})
      dec_ok = 1'b0;
  end

  // Reply assembly and write decode for the request just completed
  always_comb begin
    logic [7:0] bcc;
    logic [1:0] dlen;
    logic [3:0] n;
    logic [6:0] lvl;
    for (int i = 0; i < REPLY_MAX; i++)
      next_rep[i] = 8'h00;
    next_rep_len = 4'd1;
    wr_main = 1'b0;
    wr_dac = 1'b0;
    wr_level = 1'b0;
    wr_heater = 1'b0;
    wr_evap = 1'b0;
    read_byte = 8'h00;
    dlen = 2'd0;
    bcc = 8'h00;
    n = 4'd0;
    lvl = EVAP_POWER_LEVEL;
    next_rep[0] = CH_NAK;
    next_rep[1] = cmd_c0;
    if (cmd == RSP_CMD_NONE || bad) begin
      next_rep[0] = CH_NAK;
    end else if (is_write) begin
      // Writes land only once the whole frame and its check are in
      unique case (cmd)
        RSP_CMD_HEATER:  wr_heater = bit_ok && state == ST_EXEC;
        RSP_CMD_EVAP_SW: wr_evap = bit_ok && state == ST_EXEC;
        RSP_CMD_LEVEL:   wr_level = dec_ok && state == ST_EXEC;
        RSP_CMD_MAIN:    wr_main = hex_ok && state == ST_EXEC;
        RSP_CMD_DAC:     wr_dac = hex_ok && state == ST_EXEC;
        default:         wr_main = 1'b0;
      endcase
      if (wr_heater || wr_evap || wr_level || wr_main || wr_dac)
        next_rep[0] = CH_ACK;
    end else begin
      next_rep[0] = CH_STX;
      unique case (cmd)
        RSP_CMD_HEATER: begin
          next_rep[3] = CH_ZERO | {7'h00, main_port[MP_HEATER]};
          dlen = 2'd1;
        end
        RSP_CMD_EVAP_SW: begin
          next_rep[3] = CH_ZERO | {7'h00, main_port[MP_EVAP]};
          dlen = 2'd1;
        end
        RSP_CMD_LEVEL: begin
          next_rep[3] = (lvl == LEVEL_MAX) ? CH_ONE : CH_SPACE;
          next_rep[4] = (lvl < 7'd10) ? CH_SPACE :
                        CH_ZERO + 8'(7'((lvl % 7'd100) / 7'd10));
          next_rep[5] = CH_ZERO + 8'(7'(lvl % 7'd10));
          dlen = 2'd3;
        end
        default: begin
          dlen = 2'd0;
        end
      endcase
      if (dlen == 2'd0) begin
        unique case (cmd)
          RSP_CMD_MAIN:     read_byte = main_port;
          RSP_CMD_DAC:      read_byte = EVAP_DAC_CODE;
          RSP_CMD_INTERNAL: read_byte = internal_port;
          RSP_CMD_JUMPER:   read_byte = jumper_port;
          default:          read_byte = 8'h00;
        endcase
        next_rep[3] = CH_GT;
        if (cmd == RSP_CMD_STATUS) begin
          next_rep[4] = hex_char(status_word[15:12]);
          next_rep[5] = hex_char(status_word[11:8]);
          next_rep[6] = hex_char(status_word[7:4]);
          next_rep[7] = hex_char(status_word[3:0]);
        end else begin
          next_rep[4] = CH_ZERO;
          next_rep[5] = CH_ZERO;
          next_rep[6] = hex_char(read_byte[7:4]);
          next_rep[7] = hex_char(read_byte[3:0]);
        end
        n = 4'd8;
      end else begin
        n = 4'd3 + {2'b00, dlen};
      end
      next_rep[2] = cmd_c1_q;
      next_rep[n] = CH_ETX;
      for (int i = 1; i < REPLY_MAX; i++)
        if (i <= int'(n))
          bcc = bcc ^ next_rep[i];
      next_rep[n + 4'd1] = bcc;
      next_rep_len = n + 4'd2;
    end
  end

  // Frame parser and reply sequencer
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      state <= ST_IDLE;
      cmd <= RSP_CMD_NONE;
      cmd_c0 <= 8'h00;
      cmd_c1_q <= 8'h00;
      addr_cnt <= 3'd0;
      is_write <= 1'b0;
      bad <= 1'b0;
      pay_len <= 3'd0;
      rx_bcc <= 8'h00;
      rep_len <= 4'd0;
      tx_idx <= 4'd0;
      RX_READY <= 1'b0;
      TX_VALID <= 1'b0;
      TX_DATA <= 8'h00;
      for (int i = 0; i < PAYLOAD_MAX; i++)
        pay[i] <= 8'h00;
      for (int i = 0; i < REPLY_MAX; i++)
        rep[i] <= 8'h00;
    end else begin
      RX_READY <= init_done && state != ST_EXEC && state != ST_SEND;
      if (take && RX_DATA == CH_EOT && state != ST_WBCC) begin
        state <= ST_ADDR;
        addr_cnt <= 3'd0;
        bad <= 1'b0;
        pay_len <= 3'd0;
      end else if (take) begin
        unique case (state)
          ST_IDLE: state <= ST_IDLE;
          ST_ADDR: begin
            if (RX_DATA != CH_ZERO)
              bad <= 1'b1;
            addr_cnt <= addr_cnt + 3'd1;
            if (addr_cnt == 3'(ADDR_ZEROS - 1))
              state <= ST_FIRST;
          end
          ST_FIRST: begin
            is_write <= (RX_DATA == CH_STX);
            rx_bcc <= 8'h00;
            cmd_c0 <= RX_DATA;
            state <= (RX_DATA == CH_STX) ? ST_WCMD0 : ST_RCMD1;
          end
          ST_RCMD1, ST_WCMD1: begin
            cmd_c1_q <= RX_DATA;
            cmd <= decode(cmd_c0, RX_DATA);
            rx_bcc <= rx_bcc ^ RX_DATA;
            state <= (state == ST_RCMD1) ? ST_RENQ : ST_WDATA;
          end
          ST_RENQ: begin
            if (RX_DATA == CH_ENQ)
              state <= ST_EXEC;
            else
              bad <= 1'b1;
          end
          ST_WCMD0: begin
            cmd_c0 <= RX_DATA;
            rx_bcc <= RX_DATA;
            state <= ST_WCMD1;
          end
          ST_WDATA: begin
            rx_bcc <= rx_bcc ^ RX_DATA;
            if (RX_DATA == CH_ETX) begin
              state <= ST_WBCC;
            end else if (pay_len == 3'(PAYLOAD_MAX)) begin
              bad <= 1'b1;
            end else begin
              pay[pay_len] <= RX_DATA;
              pay_len <= pay_len + 3'd1;
            end
          end
          ST_WBCC: begin
            if (RX_DATA != rx_bcc)
              bad <= 1'b1;
            state <= ST_EXEC;
          end
          default: state <= state;
        endcase
      end else if (state == ST_EXEC) begin
        for (int i = 0; i < REPLY_MAX; i++)
          rep[i] <= next_rep[i];
        rep_len <= next_rep_len;
        TX_DATA <= next_rep[0];
        TX_VALID <= 1'b1;
        tx_idx <= 4'd1;
        RX_READY <= 1'b0;
        state <= ST_SEND;
      end else if (state == ST_SEND && TX_READY) begin
        if (tx_idx == rep_len) begin
          TX_VALID <= 1'b0;
          state <= ST_IDLE;
        end else begin
          TX_DATA <= rep[tx_idx];
          tx_idx <= tx_idx + 4'd1;
        end
      end
    end
  end

  // Valve jumpers are caught on the first edge after reset release
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      init_done <= 1'b0;
      main_port <= 8'h00;
    end else if (!init_done) begin
      init_done <= 1'b1;
      main_port[7:MP_VALVE] <= VALVE_JUMPER;
    end else if (wr_main) begin
      main_port <= hex_byte;
    end else if (wr_heater) begin
      main_port[MP_HEATER] <= pay[0][0];
    end else if (wr_evap) begin
      main_port[MP_EVAP] <= pay[0][0];
    end
  end

  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      EVAP_DAC_CODE <= DAC_RESET;
      EVAP_POWER_LEVEL <= LEVEL_RESET;
    end else begin
      if (wr_dac)
        EVAP_DAC_CODE <= hex_byte;
      if (wr_level)
        EVAP_POWER_LEVEL <= dec_val[6:0];
    end
  end

  // Pin outputs follow the main port from a flop of their own
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      HEATER_ON <= 1'b0;
      EVAP_HEATER_ON <= 1'b0;
      SPARE_OUTPUT_A <= 1'b0;
      SPARE_OUTPUT_B <= 1'b0;
      VALVE_OUT <= 4'h0;
    end else begin
      HEATER_ON <= main_port[MP_HEATER];
      EVAP_HEATER_ON <= main_port[MP_EVAP];
      SPARE_OUTPUT_A <= main_port[MP_SPARE_A];
      SPARE_OUTPUT_B <= main_port[MP_SPARE_B];
      VALVE_OUT <= main_port[7:MP_VALVE];
    end
  end

endmodule

// ---- test/rsp_cmd_port_asserts.sv ----
// Purpose: Port-level assertions for the command port handler.
// Assumes: Single clock domain, reset released between frames.
// Notes:   Reply latency figures follow the hand-over timing.
`timescale 1ns/1ps
module rsp_cmd_port_asserts
  import rsp_pkg::*;
(
  input wire logic       MCLK,
  input wire logic       RST_N,
  input wire logic [7:0] RX_DATA,
  input wire logic       RX_VALID,
  input wire logic       RX_READY,
  input wire logic [7:0] TX_DATA,
  input wire logic       TX_VALID,
  input wire logic       TX_READY,
  input wire logic [3:0] VALVE_JUMPER,
  input wire logic       HEATER_ON,
  input wire logic       EVAP_HEATER_ON,
  input wire logic [3:0] VALVE_OUT,
  input wire logic [7:0] EVAP_DAC_CODE,
  input wire logic [6:0] EVAP_POWER_LEVEL
);
  default clocking @(posedge MCLK); endclocking
  default disable iff (!RST_N);

  a_heater_reset: assert property ($rose(RST_N) |-> !HEATER_ON)
    else $error("probe heater on after reset");
  a_level_reset: assert property ($rose(RST_N) |->
    EVAP_POWER_LEVEL == LEVEL_RESET && EVAP_DAC_CODE == DAC_RESET)
    else $error("evaporator power not zero after reset");
  a_evap_reset: assert property ($rose(RST_N) |-> !EVAP_HEATER_ON)
    else $error("nitrogen heater on after reset");
  a_valve_init: assert property ($rose(RST_N) |->
    ##2 VALVE_OUT == $past(VALVE_JUMPER, 2))
    else $error("valves differ from jumpers after reset");
  a_level_max: assert property (EVAP_POWER_LEVEL <= LEVEL_MAX)
    else $error("power level above maximum");
  a_tx_hold: assert property (TX_VALID && !TX_READY |=>
    TX_VALID && $stable(TX_DATA))
    else $error("reply character dropped before taken");
  a_rx_stall: assert property (TX_VALID |-> !RX_READY)
    else $error("receiving while replying");
  a_reply_start: assert property (
    RX_VALID && RX_READY && RX_DATA == CH_ENQ |-> ##2 TX_VALID &&
    (TX_DATA == CH_STX || TX_DATA == CH_NAK || TX_DATA == CH_ACK))
    else $error("read request not answered in time");

  c_ack: cover property (TX_VALID && TX_READY && TX_DATA == CH_ACK);
  c_nak: cover property (TX_VALID && TX_READY && TX_DATA == CH_NAK);
  c_stall: cover property (TX_VALID && !TX_READY);
endmodule

bind rsp_cmd_port rsp_cmd_port_asserts u_rsp_cmd_port_asserts (
  .MCLK, .RST_N, .RX_DATA, .RX_VALID, .RX_READY, .TX_DATA, .TX_VALID,
  .TX_READY, .VALVE_JUMPER, .HEATER_ON, .EVAP_HEATER_ON, .VALVE_OUT,
  .EVAP_DAC_CODE, .EVAP_POWER_LEVEL
);

// ---- test/rsp_host.sv ----
// Purpose: Host computer model issuing framed requests.
// Assumes: One character moves per valid-ready handshake.
// Notes:   slow takes replies one cycle in four to stall the block.
`timescale 1ns/1ps
module rsp_host
  import rsp_pkg::*;
(
  input  wire logic       MCLK,
  output logic [7:0]      RX_DATA,
  output logic            RX_VALID,
  input  wire logic       RX_READY,
  input  wire logic [7:0] TX_DATA,
  input  wire logic       TX_VALID,
  output logic            TX_READY
);
  logic [7:0] rsp[$];
  logic       done;
  logic       etx_seen;
  logic       slow;
  logic       hung;
  logic [1:0] cnt;

  initial begin
    RX_DATA = 8'h00;
    RX_VALID = 1'b0;
    TX_READY = 1'b0;
    slow = 1'b0;
    hung = 1'b0;
    cnt = 2'h0;
  end

  always @(posedge MCLK) begin
    cnt <= cnt + 2'h1;
    TX_READY <= #1 (!slow || cnt == 2'h3);
    if (TX_VALID && TX_READY) begin
      rsp.push_back(TX_DATA);
      // The byte after end-of-text is the check, whatever its value
      done = etx_seen || (rsp.size() == 1 && TX_DATA != CH_STX);
      etx_seen = !etx_seen && TX_DATA == CH_ETX;
    end
  end

  task automatic put(input logic [7:0] c);
    int n;
    n = 0;
    RX_DATA = c;
    RX_VALID = 1'b1;
    do begin
      @(posedge MCLK);
      n++;
    end while (!RX_READY && n < 300);
    hung |= n >= 300;
    #1;
  endtask

  task automatic frame(input string cmd, input bit wr, input string pl);
    string      s;
    logic [7:0] b;
    int         n;
    s = {cmd, pl};
    b = CH_ETX;
    rsp = {};
    done = 1'b0;
    etx_seen = 1'b0;
    put(CH_EOT);
    repeat (ADDR_ZEROS) put(CH_ZERO);
    if (wr) put(CH_STX);
    foreach (s[i]) begin
      put(s[i]);
      b ^= s[i];
    end
    if (wr) begin
      put(CH_ETX);
      put(b);
    end else
      put(CH_ENQ);
    RX_VALID = 1'b0;
    RX_DATA = ~RX_DATA;
    n = 0;
    do begin
      @(posedge MCLK);
      #1;
      n++;
    end while (!(done && !TX_VALID) && n < 600);
    hung |= n >= 600;
  endtask
endmodule

// ---- test/tb.sv ----
// Purpose: Self-checking bench for the command port handler.
// Assumes: Host model frames requests and collects reply bytes.
// Notes:   Port expectations are built from status and jumper levels.
`timescale 1ns/1ps
module tb;
  import rsp_pkg::*;
  logic       mclk;
  logic       rst_n;
  logic [7:0] rx_data;
  logic       rx_valid;
  logic       rx_ready;
  logic [7:0] tx_data;
  logic       tx_valid;
  logic       tx_ready;
  logic [6:0] st;
  logic [3:0] jmp;
  logic       heater;
  logic       evap;
  logic       spare_a;
  logic       spare_b;
  logic [3:0] valve;
  logic [7:0] dac;
  logic [6:0] level;
  int         n_errors = 0;
  int         n_checks = 0;

  rsp_cmd_port u_rsp_cmd_port (
    .MCLK(mclk), .RST_N(rst_n), .RX_DATA(rx_data), .RX_VALID(rx_valid),
    .RX_READY(rx_ready), .TX_DATA(tx_data), .TX_VALID(tx_valid),
    .TX_READY(tx_ready), .EVAP_ATTACHED(st[0]), .GAS_MISSING(st[1]),
    .OVERHEAT(st[2]), .EXCH_ATTACHED(st[3]), .LN2_REFILL(st[4]),
    .LN2_EMPTY(st[5]), .BOOSTER_ATTACHED(st[6]), .VALVE_JUMPER(jmp),
    .HEATER_ON(heater), .EVAP_HEATER_ON(evap), .SPARE_OUTPUT_A(spare_a),
    .SPARE_OUTPUT_B(spare_b), .VALVE_OUT(valve), .EVAP_DAC_CODE(dac),
    .EVAP_POWER_LEVEL(level)
  );

  rsp_host u_rsp_host (
    .MCLK(mclk), .RX_DATA(rx_data), .RX_VALID(rx_valid),
    .RX_READY(rx_ready), .TX_DATA(tx_data), .TX_VALID(tx_valid),
    .TX_READY(tx_ready)
  );

  task automatic results();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [15:0] e,
                     input logic [15:0] g);
    n_checks++;
    if (g !== e) begin
      n_errors++;
      $display("unexpected %s exp %h got %h", nm, e, g);
    end
  endtask

  function automatic string px(input logic [15:0] v);
    string t;
    t = $sformatf("%04h", v);
    return {">", t.toupper()};
  endfunction

  task automatic rst();
    rst_n = 1'b0;
    repeat (5) @(posedge mclk);
    #1;
    rst_n = 1'b1;
    repeat (3) @(posedge mclk);
    #1;
  endtask

  // Empty ex means a single-character answer, given in one
  task automatic xfer(input string cmd, input bit wr, input string pl,
                      input string ex, input logic [7:0] one);
    logic [7:0] e[$];
    logic [7:0] b;
    string      s;
    u_rsp_host.frame(cmd, wr, pl);
    if (u_rsp_host.hung) begin
      n_errors++;
      results();
    end else begin
      b = CH_ETX;
      s = {cmd, ex};
      if (ex == "")
        e.push_back(one);
      else begin
        e.push_back(CH_STX);
        foreach (s[i]) begin
          e.push_back(s[i]);
          b ^= s[i];
        end
        e.push_back(CH_ETX);
        e.push_back(b);
      end
      chk({cmd, " length"}, e.size(), u_rsp_host.rsp.size());
      foreach (e[i])
        if (i < u_rsp_host.rsp.size())
          chk({cmd, " reply"}, e[i], u_rsp_host.rsp[i]);
    end
  endtask

  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end

  initial begin
    st = 7'h00;
    jmp = 4'ha;
    rst();
    chk("valves", 4'ha, valve);
    xfer("HP", 0, "", "0", 0);
    xfer("NP", 0, "", "0", 0);
    xfer("NH", 0, "", "  0", 0);
    xfer("P4", 0, "", px(16'h00a0), 0);
    xfer("P1", 0, "", px(16'h00a0), 0);
    xfer("HP", 1, "1", "", CH_ACK);
    chk("heater", 1, heater);
    xfer("HP", 1, "2", "", CH_NAK);
    xfer("HP", 0, "", "1", 0);
    xfer("NP", 1, "1", "", CH_ACK);
    xfer("NP", 0, "", "1", 0);
    chk("evap heater", 1, evap);
    xfer("P4", 0, "", px(16'h00a8), 0);
    xfer("NH", 1, "00042", "", CH_ACK);
    chk("level", 42, level);
    xfer("NH", 1, "101", "", CH_NAK);
    xfer("NH", 1, "  100", "", CH_ACK);
    xfer("NH", 0, "", "100", 0);
    xfer("P2", 1, "A5", "", CH_ACK);
    chk("dac", 8'ha5, dac);
    xfer("P2", 0, "", px(16'h00a5), 0);
    u_rsp_host.slow = 1'b1;
    xfer("P1", 1, "3C", "", CH_ACK);
    chk("pins", 8'h3c, {valve, spare_b, evap, spare_a, heater});
    xfer("P1", 0, "", px(16'h003c), 0);
    u_rsp_host.slow = 1'b0;
    xfer("IS", 1, "0000", "", CH_NAK);
    for (int k = 0; k < 2; k++) begin
      st = k ? 7'h2a : 7'h55;
      xfer("IS", 0, "", px({5'h0, st[6], 2'h3, st[5:0], 2'h0}), 0);
      xfer("P3", 0, "", px({8'h00, st[5:0], st[6], 1'b0}), 0);
    end
    jmp = 4'h5;
    rst();
    chk("reset pins", 16'h0050, {dac, valve, evap, heater, level[1:0]});
    xfer("P1", 0, "", px(16'h0050), 0);
    xfer("NH", 0, "", "  0", 0);
    results();
  end
endmodule
